// File: dsmc_top.sv
/*
  dsmc_top: serial-mode control, serial shifter and synth detect.
  Assumes host register port on ref_clk_i; serial and synth pins each
  bring their own clock from outside.
*/
`timescale 1ns/100ps
module dsmc_top #(
  parameter int WORD_MAX = 16
) (
  // clocks, reset, enable
  input  wire logic             ref_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic             serial_bit_clock_i,
  input  wire logic             synth_clk_i,
  // host port
  input  wire logic [2:0]       host_addr_i,
  input  wire logic             host_wr_i,
  input  wire logic             host_rd_i,
  input  wire logic [7:0]       host_wdata_i,
  output logic      [7:0]       host_rdata_o,
  // dsp serial pins
  input  wire logic             serial_mode_request_i,
  input  wire logic             rx_frame_sync_i,
  input  wire logic             tx_frame_sync_i,
  input  wire logic             rx_serial_in_i,
  output logic                  tx_serial_out_o,
  output logic                  tx_serial_oe_o,
  input  wire logic [15:0]      tx_word_i,
  output logic      [15:0]      rx_word_o,
  output logic                  rx_word_valid_o,
  // synthesizer
  input  wire logic             synth_data_i,
  // host-programmed normal settings
  input  wire logic [1:0]       host_input_source_i,
  input  wire logic [3:0]       host_input_volume_i,
  input  wire logic [3:0]       host_master_volume_i,
  input  wire logic             host_mic_bypass_i,
  input  wire logic [3:0]       host_analog_cfg_i,
  // effective analog controls
  output logic                  serial_mode_o,
  output logic                  fm_from_synth_o,
  output logic                  dac_block_o,
  output logic      [1:0]       input_source_select_o,
  output logic      [3:0]       input_volume_o,
  output logic                  mic_preamp_bypass_o,
  output logic      [3:0]       output_volume_o,
  output logic      [2:0]       speaker_out_o,
  output logic                  left_ad_mode_o,
  output logic                  right_ad_mode_o,
  output logic      [1:0]       analog_route_select_o,
  output logic                  duplex_out_node_o,
  output logic                  duplex_in_node_o
);

  // ==========================================================
  // register file
  logic [7:0] index_reg;
  logic [7:0] serial_input_override;
  logic [7:0] serial_output_override;
  logic [7:0] serial_analog_control;
  logic [7:0] serial_control;

  function automatic logic hit(input logic [7:0] idx);
    hit = host_wr_i && host_addr_i == dsmc_pkg::PORT_DATA && index_reg == idx;
  endfunction

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      index_reg              <= dsmc_pkg::REG_RESET;
      serial_input_override  <= dsmc_pkg::REG_RESET;
      serial_output_override <= dsmc_pkg::REG_RESET;
      serial_analog_control  <= dsmc_pkg::REG_RESET;
      serial_control         <= dsmc_pkg::REG_RESET;
    end
    else if (clk_en_i)
    begin
      if (host_wr_i && host_addr_i == dsmc_pkg::PORT_INDEX)
        index_reg <= host_wdata_i;
      if (hit(dsmc_pkg::IDX_IN_OVR))
        serial_input_override <= host_wdata_i;
      if (hit(dsmc_pkg::IDX_OUT_OVR))
        serial_output_override <= host_wdata_i;
      if (hit(dsmc_pkg::IDX_ANA_CTL))
        serial_analog_control <= host_wdata_i;
      if (hit(dsmc_pkg::IDX_SER_CTL))
        serial_control <= host_wdata_i;
    end

  // read data, unknown index reads zero
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
      host_rdata_o <= 8'h00;
    else if (clk_en_i && host_rd_i)
    begin
      if (host_addr_i == dsmc_pkg::PORT_INDEX)
        host_rdata_o <= index_reg;
      else if (host_addr_i != dsmc_pkg::PORT_DATA)
        host_rdata_o <= 8'h00;
      else
        unique case (index_reg)
          dsmc_pkg::IDX_IN_OVR:  host_rdata_o <= serial_input_override;
          dsmc_pkg::IDX_OUT_OVR: host_rdata_o <= serial_output_override;
          dsmc_pkg::IDX_ANA_CTL: host_rdata_o <= serial_analog_control;
          dsmc_pkg::IDX_SER_CTL: host_rdata_o <= serial_control;
          default:               host_rdata_o <= 8'h00;
        endcase
    end

  // ==========================================================
  // serial mode request, synchronised
  logic req_s1;
  logic req_s2;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
    end
    else if (clk_en_i)
    begin
      req_s1 <= serial_mode_request_i;
      req_s2 <= req_s1;
    end

  logic serial_mode;
  // request pin, force bit overrides it
  assign serial_mode   = req_s2 | serial_control[dsmc_pkg::FORCE_BIT];
  assign serial_mode_o = serial_mode;
  // playback data kept off the D/A in serial mode
  assign dac_block_o   = serial_mode;

  // ==========================================================
  // override muxing; the routing outputs are levels, not data
  logic in_ovr;
  logic out_ovr;
  logic ana_ovr;
  assign in_ovr  = serial_mode & serial_input_override[dsmc_pkg::OVR_BIT];
  assign out_ovr = serial_mode & serial_output_override[dsmc_pkg::OVR_BIT];
  // analog bits only with mode and override
  assign ana_ovr = serial_mode & serial_analog_control[dsmc_pkg::OVR_BIT];

  // source code passed straight to the mux select
  assign input_source_select_o = in_ovr ? serial_input_override[5:4] : host_input_source_i;
  assign input_volume_o = in_ovr ? serial_input_override[3:0] : host_input_volume_i;
  assign mic_preamp_bypass_o = in_ovr ? serial_input_override[dsmc_pkg::MIC_BYP_BIT]
                                      : host_mic_bypass_i;
  assign output_volume_o = out_ovr ? serial_output_override[3:0] : host_master_volume_i;

  // speaker selection; reserved code treated as mute
  always_comb
  begin
    speaker_out_o = 3'h4;
    if (serial_mode)
      speaker_out_o = (serial_output_override[6:4] == dsmc_pkg::SPK_RSVD)
                    ? dsmc_pkg::SPK_MUTE : serial_output_override[6:4];
  end

  assign left_ad_mode_o  = ana_ovr ? serial_analog_control[dsmc_pkg::LEFT_AD_BIT]
                                   : host_analog_cfg_i[3];
  assign right_ad_mode_o = ana_ovr ? serial_analog_control[dsmc_pkg::RIGHT_AD_BIT]
                                   : host_analog_cfg_i[2];
  assign analog_route_select_o = ana_ovr ? serial_analog_control[3:2]
                                         : host_analog_cfg_i[1:0];
  assign duplex_out_node_o = ana_ovr & serial_analog_control[dsmc_pkg::DOUT_EN_BIT];
  assign duplex_in_node_o  = ana_ovr & serial_analog_control[dsmc_pkg::DIN_EN_BIT];

  // ==========================================================
  // serial link, on the DSP bit clock
  logic       pol_b1;
  logic       pol_b2;
  logic       wide_b1;
  logic       wide_b2;
  logic [4:0] tx_cnt;
  logic [15:0] tx_sh;
  logic [4:0] rx_cnt;
  logic [15:0] rx_sh;
  logic       rx_tog;
  logic       fsr_act;
  logic       fsx_act;
  logic [4:0] wlen;

  // config levels crossed in with two flops
  always_ff @(posedge serial_bit_clock_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      pol_b1  <= 1'b0;
      pol_b2  <= 1'b0;
      wide_b1 <= 1'b0;
      wide_b2 <= 1'b0;
    end
    else
    begin
      pol_b1  <= serial_control[dsmc_pkg::SYNC_LOW_BIT];
      pol_b2  <= pol_b1;
      wide_b1 <= serial_control[dsmc_pkg::WIDE_BIT];
      wide_b2 <= wide_b1;
    end

  assign fsr_act = rx_frame_sync_i ^ pol_b2;
  assign fsx_act = tx_frame_sync_i ^ pol_b2;
  assign wlen    = wide_b2 ? 5'd16 : 5'd8;

  // shift out msb first on each request
  always_ff @(posedge serial_bit_clock_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      tx_cnt <= 5'd0;
      tx_sh  <= 16'h0000;
    end
    else if (fsx_act)
    begin
      tx_cnt <= wlen;
      tx_sh  <= wide_b2 ? tx_word_i : {tx_word_i[7:0], 8'h00};
    end
    else if (tx_cnt != 5'd0)
    begin
      tx_cnt <= tx_cnt - 5'd1;
      tx_sh  <= {tx_sh[14:0], 1'b0};
    end

  // pin driven only while bits remain
  assign tx_serial_oe_o  = tx_cnt != 5'd0;
  assign tx_serial_out_o = tx_sh[15];

  always_ff @(posedge serial_bit_clock_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      rx_cnt <= 5'd0;
      rx_sh  <= 16'h0000;
      rx_tog <= 1'b0;
    end
    else if (fsr_act)
      rx_cnt <= wlen;
    else if (rx_cnt != 5'd0)
    begin
      rx_sh  <= {rx_sh[14:0], rx_serial_in_i};
      rx_cnt <= rx_cnt - 5'd1;
      if (rx_cnt == 5'd1)
        rx_tog <= ~rx_tog;
    end

  // word handed to ref domain by toggle; word stable until next frame
  logic rt1;
  logic rt2;
  logic rt3;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      rt1             <= 1'b0;
      rt2             <= 1'b0;
      rt3             <= 1'b0;
      rx_word_o       <= 16'h0000;
      rx_word_valid_o <= 1'b0;
    end
    else if (clk_en_i)
    begin
      rt1             <= rx_tog;
      rt2             <= rt1;
      rt3             <= rt2;
      rx_word_valid_o <= rt2 ^ rt3;
      if (rt2 ^ rt3)
        rx_word_o <= rx_sh;
    end

  // ==========================================================
  // synth activity on its own clock
  logic       sd_1;
  logic       sd_2;
  logic       sd_3;
  logic [6:0] quiet_cnt;
  logic       syn_act;
  logic [2:0] sa_s;
  always_ff @(posedge synth_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      sd_1      <= 1'b0;
      sd_2      <= 1'b0;
      sd_3      <= 1'b0;
      quiet_cnt <= 7'd0;
      syn_act   <= 1'b0;
    end
    else
    begin
      sd_1 <= synth_data_i;
      sd_2 <= sd_1;
      sd_3 <= sd_2;
      if (sd_2 != sd_3)
      begin
        quiet_cnt <= 7'd0;
        syn_act   <= 1'b1;
      end
      else if (quiet_cnt >= 7'(dsmc_pkg::SYN_WINDOW - 1))
        syn_act <= 1'b0;
      else
        quiet_cnt <= quiet_cnt + 7'd1;
    end

  // a stopped synth clock freezes syn_act, so watch for its edges
  logic sc_1;
  logic sc_2;
  logic sc_3;
  logic [6:0] clk_quiet;
  logic clk_live;
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
    if (!arst_n_i)
    begin
      sa_s      <= 3'b000;
      sc_1      <= 1'b0;
      sc_2      <= 1'b0;
      sc_3      <= 1'b0;
      clk_quiet <= 7'd0;
      clk_live  <= 1'b0;
    end
    else if (clk_en_i)
    begin
      sa_s <= {sa_s[1:0], syn_act};
      sc_1 <= synth_clk_i;
      sc_2 <= sc_1;
      sc_3 <= sc_2;
      if (sc_2 != sc_3)
      begin
        clk_quiet <= 7'd0;
        clk_live  <= 1'b1;
      end
      else if (clk_quiet == 7'h7F)
        clk_live <= 1'b0;
      else
        clk_quiet <= clk_quiet + 7'd1;
    end

  // FM replaced while synth active and enabled
  assign fm_from_synth_o = sa_s[1] & clk_live & serial_control[dsmc_pkg::SYN_EN_BIT];

  // ==========================================================
  // checks
  sequence s_tx_req;
    fsx_act;
  endsequence
  AST_TX_OE: assert property (@(posedge serial_bit_clock_i) disable iff (!arst_n_i)
    s_tx_req |=> tx_serial_oe_o)
    else $error("tx not driven after request");
  AST_TX_HIZ: assert property (@(posedge serial_bit_clock_i) disable iff (!arst_n_i)
    (tx_cnt == 5'd0) |-> !tx_serial_oe_o)
    else $error("tx driven while idle");
  AST_FORCE: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    serial_control[dsmc_pkg::FORCE_BIT] |-> serial_mode_o)
    else $error("force bit ignored");
  AST_REQ: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    (clk_en_i && $rose(req_s2)) |-> serial_mode_o)
    else $error("request not followed");
  AST_NO_OVR: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    !serial_mode_o |-> input_volume_o == host_input_volume_i
                       && output_volume_o == host_master_volume_i)
    else $error("override outside serial mode");
  AST_DAC: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    serial_mode_o |-> dac_block_o)
    else $error("dac not blocked");
  AST_DOUT: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    duplex_out_node_o |-> serial_mode_o && serial_analog_control[dsmc_pkg::OVR_BIT])
    else $error("duplex out without override");
  AST_SYN: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
    fm_from_synth_o |-> serial_control[dsmc_pkg::SYN_EN_BIT])
    else $error("synth takeover while disabled");
endmodule

// File: dsmc_pkg.sv
/*
  dsmc_pkg: shared constants for the serial-mode control block.
  Assumes a host index/data port pair and 8-bit extension registers.
*/
package dsmc_pkg;
  // ==========================================================
  // host port offsets and extension register indices
  localparam logic [2:0] PORT_INDEX      = 3'h4;
  localparam logic [2:0] PORT_DATA       = 3'h5;
  localparam logic [7:0] IDX_IN_OVR      = 8'h42;
  localparam logic [7:0] IDX_OUT_OVR     = 8'h44;
  localparam logic [7:0] IDX_ANA_CTL     = 8'h46;
  localparam logic [7:0] IDX_SER_CTL     = 8'h48;
  // ==========================================================
  // field positions
  localparam int OVR_BIT       = 7;
  localparam int MIC_BYP_BIT   = 6;
  localparam int LEFT_AD_BIT   = 5;
  localparam int RIGHT_AD_BIT  = 4;
  localparam int DOUT_EN_BIT   = 1;
  localparam int DIN_EN_BIT    = 0;
  localparam int FORCE_BIT     = 7;
  localparam int SYN_EN_BIT    = 4;
  localparam int SYNC_LOW_BIT  = 3;
  localparam int WIDE_BIT      = 0;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] ANA_MASK  = 7'h3F;
  // ==========================================================
  // synthesizer activity window, in synth clock periods
  localparam int SYN_WINDOW = 64;
  // ==========================================================
  // input source codes
  localparam logic [1:0] SRC_LINE  = 2'h0;
  localparam logic [1:0] SRC_AUX   = 2'h1;
  localparam logic [1:0] SRC_MIC   = 2'h2;
  localparam logic [1:0] SRC_MIXER = 2'h3;
  // speaker output codes
  localparam logic [2:0] SPK_MUTE  = 3'h0;
  localparam logic [2:0] SPK_RSVD  = 3'h7;
endpackage

// File: dsmc_dsp_model.sv
/*
  dsmc_dsp_model: behavioural DSP and synthesizer at the serial pins.
  Assumes the bench calls one task at a time; clocks stand still between calls.
*/
`timescale 1ns/100ps
module dsmc_dsp_model (
  // serial pins toward the block
  output logic        bit_clk_o,
  output logic        rx_fs_o,
  output logic        tx_fs_o,
  output logic        rx_data_o,
  // synthesizer pins
  output logic        synth_clk_o,
  output logic        synth_data_o,
  // transmit pin from the block
  input  wire logic   tx_out_i,
  input  wire logic   tx_oe_i
);
  // captured transmit bits
  logic [15:0] tx_got;
  int          tx_cnt;

  // ==========================================================
  // idle levels: pins have pull-downs, clocks stand still
  initial
  begin
    {bit_clk_o, rx_fs_o, tx_fs_o, rx_data_o, synth_clk_o, synth_data_o} = 6'h00;
    tx_got = 16'h0000;
    tx_cnt = 0;
    // a few edges inside reset so every domain clears
    #300;
    repeat (2)
    begin
      #50 bit_clk_o = 1'b1;
      synth_clk_o = 1'b1;
      #50 bit_clk_o = 1'b0;
      synth_clk_o = 1'b0;
    end
  end

  // ==========================================================
  // frame: four lead-in clocks let the sync polarity settle first
  // sync then bits
  task automatic frame(input logic is_tx, input logic [15:0] w, input int n,
                       input logic low);
    int e;
    tx_got = 16'h0000;
    tx_cnt = 0;
    for (e = 0; e < n + 8; e++)
    begin
      rx_fs_o = low ^ (!is_tx && e == 4);
      tx_fs_o = low ^ (is_tx && e == 4);
      rx_data_o = (!is_tx && e > 4 && e <= n + 4) ? w[n + 4 - e] : 1'b0;
      // a polarity change can start a stray word in the lead-in; count from the sync
      if (e == 4)
      begin
        tx_got = 16'h0000;
        tx_cnt = 0;
      end
      #24 bit_clk_o = 1'b1;
      #24 bit_clk_o = 1'b0;
      if (tx_oe_i === 1'b1)
      begin
        tx_got = {tx_got[14:0], tx_out_i};
        tx_cnt++;
      end
    end
  endtask

  // synth clock, data flips on falling edges
  task automatic synth(input int n, input logic tog);
    repeat (n)
    begin
      #182 synth_clk_o = 1'b1;
      #182 synth_clk_o = 1'b0;
      synth_data_o = synth_data_o ^ tog;
    end
  endtask
endmodule

// File: dsmc_top_tb.sv
/*
  dsmc_top_tb: host register access, override, serial and synth tests.
  Assumes dsmc_dsp_model stands in for the DSP and the synthesizer.
*/
`timescale 1ns/100ps
module dsmc_top_tb;
  // host-programmed normal settings
  localparam logic [1:0] H_SRC  = 2'h1;
  localparam logic [3:0] H_INV  = 4'h3;
  localparam logic [3:0] H_MVOL = 4'hC;
  localparam logic [3:0] H_CFG  = 4'h6;
  // clock, reset, host port
  logic        ref_clk_i;
  logic        arst_n_i;
  logic        clk_en;
  logic [2:0]  host_addr_i;
  logic        host_wr_i;
  logic        host_rd_i;
  logic [7:0]  host_wdata_i;
  logic [7:0]  host_rdata_o;
  logic        h_byp;
  // serial and synth pins
  logic        bit_clk, rx_fs, tx_fs, rx_data, syn_clk, syn_data, tx_out, tx_oe, req;
  logic [15:0] tx_word, rx_word;
  logic        rx_valid;
  // effective analog controls
  logic        smode, fm_syn, dac_blk, byp, l_ad, r_ad, d_out, d_in;
  logic [1:0]  src, route;
  logic [3:0]  in_vol, out_vol;
  logic [2:0]  spk;
  logic [15:0] mix_v;
  logic [5:0]  ana_v;
  // bench state
  int          err_count;
  int          checked;
  int          n;
  logic [7:0]  rd;
  logic        ok;
  logic [7:0]  idx_tab [4] = '{8'h42, 8'h44, 8'h46, 8'h4A};
  logic [7:0]  val_tab [4] = '{8'hE9, 8'h85, 8'hB6, 8'h00};

  // packed views so one compare covers many outputs
  assign mix_v = {src, in_vol, byp, out_vol, spk, dac_blk, smode};
  assign ana_v = {l_ad, r_ad, route, d_out, d_in};

  dsmc_top dsmc_top_i (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .clk_en_i(clk_en),
    .serial_bit_clock_i(bit_clk), .synth_clk_i(syn_clk), .host_addr_i(host_addr_i),
    .host_wr_i(host_wr_i), .host_rd_i(host_rd_i), .host_wdata_i(host_wdata_i),
    .host_rdata_o(host_rdata_o), .serial_mode_request_i(req), .rx_frame_sync_i(rx_fs),
    .tx_frame_sync_i(tx_fs), .rx_serial_in_i(rx_data), .tx_serial_out_o(tx_out),
    .tx_serial_oe_o(tx_oe), .tx_word_i(tx_word), .rx_word_o(rx_word),
    .rx_word_valid_o(rx_valid), .synth_data_i(syn_data), .host_input_source_i(H_SRC),
    .host_input_volume_i(H_INV), .host_master_volume_i(H_MVOL), .host_mic_bypass_i(h_byp),
    .host_analog_cfg_i(H_CFG), .serial_mode_o(smode), .fm_from_synth_o(fm_syn),
    .dac_block_o(dac_blk), .input_source_select_o(src), .input_volume_o(in_vol),
    .mic_preamp_bypass_o(byp), .output_volume_o(out_vol), .speaker_out_o(spk),
    .left_ad_mode_o(l_ad), .right_ad_mode_o(r_ad), .analog_route_select_o(route),
    .duplex_out_node_o(d_out), .duplex_in_node_o(d_in));

  dsmc_dsp_model dsmc_dsp_model_i (.bit_clk_o(bit_clk), .rx_fs_o(rx_fs), .tx_fs_o(tx_fs),
    .rx_data_o(rx_data), .synth_clk_o(syn_clk), .synth_data_o(syn_data),
    .tx_out_i(tx_out), .tx_oe_i(tx_oe));

  // ==========================================================
  // 10 MHz reference clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // ==========================================================
  // compare and report tasks
  task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    chk_sig({8'h00, got}, {8'h00, exp});
  endtask

  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // an exhausted wait ends the run at once
  task automatic bound(input logic good);
    if (!good)
    begin
      err_count++;
      complete_run();
    end
  endtask

  // ==========================================================
  // host port: one access per cycle, driven 1 ns after the edge
  task automatic host_cyc(input logic [2:0] a, input logic [7:0] d, input logic w,
                          input logic r);
    host_addr_i = a;
    host_wdata_i = d;
    host_wr_i = w;
    host_rd_i = r;
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] d);
    host_cyc(3'h4, idx, 1'b1, 1'b0);
    host_cyc(3'h5, d, 1'b1, 1'b0);
    host_cyc(3'h5, 8'h00, 1'b0, 1'b0);
  endtask

  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] d);
    host_cyc(3'h4, idx, 1'b1, 1'b0);
    host_cyc(3'h5, 8'h00, 1'b0, 1'b1);
    d = host_rdata_o;
    host_cyc(3'h5, 8'h00, 1'b0, 1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    {arst_n_i, host_wr_i, host_rd_i, req, h_byp} = 5'h00;
    {host_addr_i, host_wdata_i} = 11'h000;
    clk_en = 1'b1;
    tx_word = 16'h5A96;
    err_count = 0;
    checked = 0;
    repeat (12) @(posedge ref_clk_i);
    #1 arst_n_i = 1'b1;
    @(posedge ref_clk_i);
    #1;
    // reset values, then writes incl. an unknown index that must stay 0
    for (n = 0; n < 4; n++)
    begin
      rd_reg(idx_tab[n], rd);
      chk_reg(rd, 8'h00);
      wr_reg(idx_tab[n], (n == 3) ? 8'hFF : val_tab[n]);
    end
    for (n = 0; n < 4; n++)
    begin
      rd_reg(idx_tab[n], rd);
      chk_reg(rd, val_tab[n]);
    end
    chk_sig(mix_v, {H_SRC, H_INV, 1'b0, H_MVOL, 3'h4, 1'b0, 1'b0});
    chk_sig({10'h000, ana_v}, {10'h000, H_CFG, 2'b00});
    $display("test registers done");
    // forced serial mode applies every override
    wr_reg(8'h48, 8'h80);
    chk_sig(mix_v, {2'h2, 4'h9, 1'b1, 4'h5, 3'h0, 1'b1, 1'b1});
    chk_sig({10'h000, ana_v}, {10'h000, 6'b110110});
    for (n = 0; n < 4; n++)
    begin
      wr_reg(8'h42, {2'b10, n[1:0], 4'h9});
      chk_sig({13'h0000, src, byp}, {13'h0000, n[1:0], 1'b0});
    end
    for (n = 0; n < 8; n++)
    begin
      wr_reg(8'h44, {1'b0, n[2:0], 4'h5});
      chk_sig({9'h000, out_vol, spk}, {9'h000, H_MVOL, (n == 7) ? 3'h0 : n[2:0]});
    end
    // route select 2 with both duplex nodes off, both converters in D/A mode
    wr_reg(8'h46, 8'h88);
    chk_sig({10'h000, ana_v}, {10'h000, 6'b001000});
    wr_reg(8'h46, 8'h36);
    chk_sig({10'h000, ana_v}, {10'h000, H_CFG, 2'b00});
    $display("test overrides done");
    // request pin alone controls serial mode once force is clear
    wr_reg(8'h48, 8'h00);
    chk_sig({15'h0000, smode}, 16'h0000);
    req = 1'b1;
    for (n = 0; n < 10 && smode !== 1'b1; n++) @(posedge ref_clk_i);
    #1 bound(smode === 1'b1);
    chk_sig({15'h0000, smode}, 16'h0001);
    $display("test request done");
    // transmit 8 bits active high, then 16 bits active low
    chk_sig({15'h0000, tx_oe}, 16'h0000);
    dsmc_dsp_model_i.frame(1'b1, 16'h0000, 8, 1'b0);
    chk_sig(16'(dsmc_dsp_model_i.tx_cnt), 16'h0008);
    chk_sig(dsmc_dsp_model_i.tx_got, 16'h0096);
    wr_reg(8'h48, 8'h09);
    dsmc_dsp_model_i.frame(1'b1, 16'h0000, 16, 1'b1);
    chk_sig(16'(dsmc_dsp_model_i.tx_cnt), 16'h0010);
    chk_sig(dsmc_dsp_model_i.tx_got, 16'h5A96);
    chk_sig({15'h0000, tx_oe}, 16'h0000);
    $display("test transmit done");
    // receive 16 bits active low, waiting for the valid pulse
    ok = 1'b0;
    fork
      dsmc_dsp_model_i.frame(1'b0, 16'hC3A5, 16, 1'b1);
      for (n = 0; n < 400 && !ok; n++)
      begin
        @(posedge ref_clk_i);
        #1 ok = (rx_valid === 1'b1);
      end
    join
    bound(ok);
    chk_sig(rx_word, 16'hC3A5);
    $display("test receive done");
    // synth activity with and without the enable bit
    wr_reg(8'h48, 8'h10);
    dsmc_dsp_model_i.synth(140, 1'b1);
    chk_sig({15'h0000, fm_syn}, 16'h0001);
    // a stopped synth clock must end the takeover
    repeat (200) @(posedge ref_clk_i);
    #1;
    chk_sig({15'h0000, fm_syn}, 16'h0000);
    dsmc_dsp_model_i.synth(100, 1'b0);
    chk_sig({15'h0000, fm_syn}, 16'h0000);
    wr_reg(8'h48, 8'h00);
    dsmc_dsp_model_i.synth(140, 1'b1);
    chk_sig({15'h0000, fm_syn}, 16'h0000);
    $display("test synth done");
    complete_run();
  end
endmodule
